// >>> por_pkg.sv
// Package with constants and types of the protection output routing block.
package por_pkg;
	// ----------------------------------------
	// Setting selectors
	// ----------------------------------------
	localparam int GROUP_COUNT = 10;
	localparam logic [3:0] SEL_RETENTION = 4'hA;
	localparam logic [3:0] SEL_REPLACE_TIMER = 4'hB;
	// ----------------------------------------
	// Reset values, masks and limits
	// ----------------------------------------
	localparam logic [3:0] START_GROUP_RESET = 4'hC;
	localparam logic [3:0] TRIP_GROUP_RESET = 4'h3;
	localparam logic [7:0] RETENTION_RESET = 8'h1F;
	localparam logic [7:0] RETENTION_USED_MASK = 8'h1F;
	localparam logic [9:0] REPLACE_TIMER_RESET = 10'h03C;
	localparam logic [9:0] REPLACE_TIMER_MAX = 10'h3E6;
	localparam logic [9:0] REPLACE_NEVER = 10'h3E7;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_POWER_ONE = 0;
	localparam int BIT_POWER_TWO = 1;
	localparam int BIT_SIGNAL_ONE = 2;
	localparam int BIT_SIGNAL_TWO = 3;
	localparam int RET_INDICATIONS = 0;
	localparam int RET_START_COUNTERS = 1;
	localparam int RET_DISTURBANCE = 2;
	localparam int RET_EVENTS = 3;
	localparam int RET_MEASUREMENTS = 4;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint CLOCK_HZ = 10000000;
	localparam longint MINUTE_S = 60;
	localparam longint MINUTE_CYCLES = MINUTE_S * CLOCK_HZ;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic signal_output_two;
		logic signal_output_one;
		logic power_output_two;
		logic power_output_one;
	} por_contacts_t;
	typedef struct packed {
		logic valid;
		logic [2:0] stage;
	} por_indication_t;
endpackage : por_pkg

// >>> por_routing.sv
// Output routing matrix, new trip indication timer and retention switches.
// Notes on behaviour
// - Stage start/trip signals switched onto four contacts.
// - Group checksum is sum of selected weights.
// - Start groups reset to checksum 12.
// - Trip groups reset to checksum 3.
// - First trip shown until replace timer expires.
// - Timer minutes up to 998, default 60.
// - Setting 999 blocks replacement until manual clear.
// - Timer touches only the display, not routing.
// - Switch 1 keeps indications over power loss.
// - Switch 2 keeps start counters, default 1.
// - Switch 3 keeps disturbance records, default 1.
// - Switch 4 keeps event codes, default 1.
// - Switch 5 keeps measurement data, default 1.
// - Switches independent; 6 to 8 unused; checksum 31.
`timescale 1ns/100ps
module por_routing #(
	parameter longint MINUTE_CYCLES = por_pkg::MINUTE_CYCLES
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// Protection stage signals, order: low phase, high phase, low earth, high earth, discontinuity
	input wire logic [4:0] stage_start_i,
	input wire logic [4:0] stage_trip_i,
	// Settings port
	input wire logic setting_wr_i,
	input wire logic [3:0] setting_sel_i,
	input wire logic [9:0] setting_data_i,
	output logic [9:0] setting_rdata_o,
	// Indication control
	input wire logic indication_clear_i,
	input wire logic power_restore_i,
	// Output contacts
	output por_pkg::por_contacts_t contacts_o,
	// Display
	output por_pkg::por_indication_t indication_o,
	// Retention selections
	output logic [4:0] retain_o
);
	// ----------------------------------------
	// Settings
	// ----------------------------------------
	logic [3:0] group [por_pkg::GROUP_COUNT];
	logic [7:0] retention_select;
	logic [9:0] replace_setting;
	logic [9:0] sig;
	logic [3:0] term [por_pkg::GROUP_COUNT];
	por_pkg::por_contacts_t next_contacts;

	genvar g;
	generate
		for (g = 0; g < por_pkg::GROUP_COUNT; g++) begin : g_group
			// Bit k of a group carries weight 2**k, so the stored value is the checksum.
			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i) begin
					group[g] <= (g % 2 == 0) ? por_pkg::START_GROUP_RESET
						: por_pkg::TRIP_GROUP_RESET;
				end else if (setting_wr_i && setting_sel_i == 4'(g)) begin
					group[g] <= setting_data_i[3:0];
				end
			end
			assign sig[g] = (g % 2 == 0) ? stage_start_i[g / 2] : stage_trip_i[g / 2];
			assign term[g] = {4{sig[g]}} & group[g];
		end
	endgenerate

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			retention_select <= por_pkg::RETENTION_RESET;
		end else if (setting_wr_i && setting_sel_i == por_pkg::SEL_RETENTION) begin
			// Unused switches stay at zero whatever is written.
			retention_select <= setting_data_i[7:0] & por_pkg::RETENTION_USED_MASK;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			replace_setting <= por_pkg::REPLACE_TIMER_RESET;
		end else if (setting_wr_i && setting_sel_i == por_pkg::SEL_REPLACE_TIMER
			&& setting_data_i <= por_pkg::REPLACE_NEVER) begin
			replace_setting <= setting_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			setting_rdata_o <= 10'h000;
		end else if (setting_sel_i == por_pkg::SEL_RETENTION) begin
			setting_rdata_o <= {2'h0, retention_select};
		end else if (setting_sel_i == por_pkg::SEL_REPLACE_TIMER) begin
			setting_rdata_o <= replace_setting;
		end else if (setting_sel_i < 4'(por_pkg::GROUP_COUNT)) begin
			setting_rdata_o <= {6'h00, group[setting_sel_i]};
		end else begin
			setting_rdata_o <= 10'h000;
		end
	end

	// ----------------------------------------
	// Routing matrix
	// ----------------------------------------
	always_comb begin
		logic [3:0] acc;
		acc = 4'h0;
		for (int i = 0; i < por_pkg::GROUP_COUNT; i++) begin
			acc = acc | term[i];
		end
		next_contacts.power_output_one = acc[por_pkg::BIT_POWER_ONE];
		next_contacts.power_output_two = acc[por_pkg::BIT_POWER_TWO];
		next_contacts.signal_output_one = acc[por_pkg::BIT_SIGNAL_ONE];
		next_contacts.signal_output_two = acc[por_pkg::BIT_SIGNAL_TWO];
	end

	// The contacts depend on nothing but stage signals and groups.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			contacts_o <= '0;
		end else begin
			contacts_o <= next_contacts;
		end
	end

	// ----------------------------------------
	// New trip indication timer
	// ----------------------------------------
	logic [4:0] trip_prev;
	logic [4:0] trip_rise;
	logic [29:0] prescale;
	logic [9:0] elapsed;
	logic replace_ok;
	logic [2:0] first_rise;

	assign trip_rise = stage_trip_i & ~trip_prev;
	assign replace_ok = !indication_o.valid
		|| (replace_setting != por_pkg::REPLACE_NEVER && elapsed >= replace_setting);

	always_comb begin
		first_rise = 3'h0;
		for (int i = 4; i >= 0; i--) begin
			if (trip_rise[i]) begin
				first_rise = 3'(i);
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			trip_prev <= 5'h00;
		end else begin
			trip_prev <= stage_trip_i;
		end
	end

	// A clear loses only when a new trip arrives in the same cycle.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			indication_o <= '0;
		end else if (|trip_rise && (replace_ok || indication_clear_i)) begin
			indication_o <= {1'b1, first_rise};
		end else if (indication_clear_i
			|| (power_restore_i && !retention_select[por_pkg::RET_INDICATIONS])) begin
			indication_o <= '0;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prescale <= 30'h00000000;
			elapsed <= 10'h000;
		end else if (|trip_rise && (replace_ok || indication_clear_i)) begin
			prescale <= 30'h00000000;
			elapsed <= 10'h000;
		end else if (prescale == 30'(MINUTE_CYCLES - 1)) begin
			prescale <= 30'h00000000;
			// Saturates so a long-standing indication never wraps back to blocked.
			if (elapsed != por_pkg::REPLACE_TIMER_MAX) begin
				elapsed <= elapsed + 10'h001;
			end
		end else begin
			prescale <= prescale + 30'h00000001;
		end
	end

	// ----------------------------------------
	// Retention outputs
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			retain_o <= por_pkg::RETENTION_RESET[4:0];
		end else begin
			retain_o[0] <= retention_select[por_pkg::RET_INDICATIONS];
			retain_o[1] <= retention_select[por_pkg::RET_START_COUNTERS];
			retain_o[2] <= retention_select[por_pkg::RET_DISTURBANCE];
			retain_o[3] <= retention_select[por_pkg::RET_EVENTS];
			retain_o[4] <= retention_select[por_pkg::RET_MEASUREMENTS];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_route_power;
		@(posedge clock_i) disable iff (!resetn_i)
		##1 contacts_o.power_output_one == $past(|(sig & {group[9][0], group[8][0],
			group[7][0], group[6][0], group[5][0], group[4][0], group[3][0],
			group[2][0], group[1][0], group[0][0]}));
	endproperty
	a_route_power: assert property (p_route_power) else $error("power one routing wrong");

	property p_route_signal;
		@(posedge clock_i) disable iff (!resetn_i)
		(stage_start_i[0] && group[0][3]) |=> contacts_o.signal_output_two;
	endproperty
	a_route_signal: assert property (p_route_signal) else $error("signal two routing wrong");

	property p_trip_power;
		@(posedge clock_i) disable iff (!resetn_i)
		(stage_trip_i[0] && group[1][1]) |=> contacts_o.power_output_two;
	endproperty
	a_trip_power: assert property (p_trip_power) else $error("trip route wrong");

	property p_start_signal;
		@(posedge clock_i) disable iff (!resetn_i)
		(stage_start_i[1] && group[2][2]) |=> contacts_o.signal_output_one;
	endproperty
	a_start_signal: assert property (p_start_signal) else $error("start route wrong");

	property p_no_route;
		@(posedge clock_i) disable iff (!resetn_i)
		(stage_start_i == 5'h00 && stage_trip_i == 5'h00) |=> contacts_o == '0;
	endproperty
	a_no_route: assert property (p_no_route) else $error("contact without source");

	property p_checksum_read;
		@(posedge clock_i) disable iff (!resetn_i)
		(setting_sel_i == 4'h1) |=> setting_rdata_o == {6'h00, $past(group[1])};
	endproperty
	a_checksum_read: assert property (p_checksum_read) else $error("checksum readback");

	property p_unused_zero;
		@(posedge clock_i) disable iff (!resetn_i)
		retention_select[7:5] == 3'h0;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused switch set");

	property p_hold_first;
		@(posedge clock_i) disable iff (!resetn_i)
		(indication_o.valid && !indication_clear_i && elapsed < replace_setting
			&& !power_restore_i) |=> $stable(indication_o);
	endproperty
	a_hold_first: assert property (p_hold_first) else $error("indication replaced early");

	property p_never;
		@(posedge clock_i) disable iff (!resetn_i)
		(indication_o.valid && replace_setting == por_pkg::REPLACE_NEVER
			&& !indication_clear_i && !power_restore_i) |=> $stable(indication_o);
	endproperty
	a_never: assert property (p_never) else $error("replaced despite 999");

	property p_setting_range;
		@(posedge clock_i) disable iff (!resetn_i)
		replace_setting <= por_pkg::REPLACE_NEVER;
	endproperty
	a_setting_range: assert property (p_setting_range) else $error("timer out of range");

	property p_retain;
		@(posedge clock_i) disable iff (!resetn_i)
		##1 retain_o == $past(retention_select[4:0]);
	endproperty
	a_retain: assert property (p_retain) else $error("retention output wrong");

	property p_power_clear;
		@(posedge clock_i) disable iff (!resetn_i)
		(power_restore_i && !retention_select[0] && trip_rise == 5'h00) |=> !indication_o.valid;
	endproperty
	a_power_clear: assert property (p_power_clear) else $error("indication not cleared");

	property p_clear;
		@(posedge clock_i) disable iff (!resetn_i)
		(indication_clear_i && trip_rise == 5'h00) |=> !indication_o.valid;
	endproperty
	a_clear: assert property (p_clear) else $error("manual clear ignored");

	property p_first_taken;
		@(posedge clock_i) disable iff (!resetn_i)
		(trip_rise != 5'h00 && !indication_o.valid) |=> indication_o.valid;
	endproperty
	a_first_taken: assert property (p_first_taken) else $error("first trip lost");

	property p_keep_records;
		@(posedge clock_i) disable iff (!resetn_i)
		##1 retain_o[2] == $past(retention_select[por_pkg::RET_DISTURBANCE]);
	endproperty
	a_keep_records: assert property (p_keep_records) else $error("record switch wrong");

	property p_keep_events;
		@(posedge clock_i) disable iff (!resetn_i)
		##1 retain_o[3] == $past(retention_select[por_pkg::RET_EVENTS]);
	endproperty
	a_keep_events: assert property (p_keep_events) else $error("event switch wrong");

	property p_keep_measures;
		@(posedge clock_i) disable iff (!resetn_i)
		##1 retain_o[4] == $past(retention_select[por_pkg::RET_MEASUREMENTS]);
	endproperty
	a_keep_measures: assert property (p_keep_measures) else $error("measure switch wrong");
endmodule : por_routing

// >>> tb_por_routing.sv
// Self-checking testbench of the protection output routing block.
`timescale 1ns/100ps
module tb_por_routing;
	// Short minute keeps the indication timer test brief.
	localparam longint MIN_CYC = 10;
	logic clock_i;
	logic resetn_i;
	logic setting_wr_i;
	logic indication_clear_i;
	logic power_restore_i;
	logic [4:0] stage_start_i;
	logic [4:0] stage_trip_i;
	logic [4:0] retain_o;
	logic [3:0] setting_sel_i;
	logic [9:0] setting_data_i;
	logic [9:0] setting_rdata_o;
	por_pkg::por_contacts_t contacts_o;
	por_pkg::por_indication_t indication_o;
	logic [3:0] grp [10];
	int bad_count = 0;
	int n_compared = 0;
	por_routing #(.MINUTE_CYCLES(MIN_CYC)) dut (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.stage_start_i(stage_start_i),
		.stage_trip_i(stage_trip_i),
		.setting_wr_i(setting_wr_i),
		.setting_sel_i(setting_sel_i),
		.setting_data_i(setting_data_i),
		.setting_rdata_o(setting_rdata_o),
		.indication_clear_i(indication_clear_i),
		.power_restore_i(power_restore_i),
		.contacts_o(contacts_o),
		.indication_o(indication_o),
		.retain_o(retain_o)
	);
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task automatic step();
		@(posedge clock_i);
		#1;
	endtask : step
	task automatic wr(input logic [3:0] sel, input logic [9:0] d);
		setting_sel_i = sel;
		setting_data_i = d;
		setting_wr_i = 1'b1;
		step();
		setting_wr_i = 1'b0;
		// One idle edge keeps back-to-back writes from retoggling the strobe at once.
		step();
	endtask : wr
	task automatic rd(input logic [3:0] sel, input logic [9:0] exp);
		setting_sel_i = sel;
		step();
		check("readback", exp, setting_rdata_o);
	endtask : rd
	task automatic pulse_trip(input logic [4:0] t);
		stage_trip_i = t;
		step();
		stage_trip_i = 5'h00;
		step();
	endtask : pulse_trip
	task automatic clear_ind();
		indication_clear_i = 1'b1;
		step();
		indication_clear_i = 1'b0;
	endtask : clear_ind
	function automatic logic [3:0] route(input logic [4:0] st, input logic [4:0] tr);
		logic [3:0] r;
		r = 4'h0;
		for (int s = 0; s < 5; s++) begin
			if (st[s]) r |= grp[2 * s];
			if (tr[s]) r |= grp[2 * s + 1];
		end
		return r;
	endfunction : route
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	// Nothing here waits open-ended; this only guards against a stalled clock.
	initial begin
		#3000000;
		bad_count++;
		final_report();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(19));
		{resetn_i, setting_wr_i, indication_clear_i, power_restore_i} = 4'h0;
		{stage_start_i, stage_trip_i, setting_sel_i, setting_data_i} = 24'h000000;
		repeat (3) @(posedge clock_i);
		#1;
		resetn_i = 1'b1;
		for (int g = 0; g < 10; g++) begin
			grp[g] = g[0] ? por_pkg::TRIP_GROUP_RESET : por_pkg::START_GROUP_RESET;
			rd(4'(g), {6'h00, grp[g]});
		end
		rd(por_pkg::SEL_RETENTION, 10'h01F);
		rd(por_pkg::SEL_REPLACE_TIMER, por_pkg::REPLACE_TIMER_RESET);
		rd(4'hC, 10'h000);
		check("retain", 10'h01F, {5'h00, retain_o});
		for (int b = 0; b < 5; b++) begin
			wr(por_pkg::SEL_RETENTION, 10'h0E0 | (10'h001 << b));
			rd(por_pkg::SEL_RETENTION, 10'h001 << b);
			check("retain", 10'h001 << b, {5'h00, retain_o});
		end
		wr(por_pkg::SEL_RETENTION, 10'h01F);
		wr(por_pkg::SEL_REPLACE_TIMER, 10'h3E8);
		rd(por_pkg::SEL_REPLACE_TIMER, por_pkg::REPLACE_TIMER_RESET);
		wr(por_pkg::SEL_REPLACE_TIMER, por_pkg::REPLACE_TIMER_MAX);
		rd(por_pkg::SEL_REPLACE_TIMER, por_pkg::REPLACE_TIMER_MAX);
		// First pass runs on the reset routing, the rest on random groups.
		for (int n = 0; n < 40; n++) begin
			stage_start_i = 5'($urandom);
			stage_trip_i = 5'($urandom);
			step();
			check("contacts", {6'h00, route(stage_start_i, stage_trip_i)}, {6'h00, contacts_o});
			for (int g = 0; g < 10; g++) begin
				grp[g] = 4'($urandom);
				wr(4'(g), {6'h3F, grp[g]});
			end
			rd(4'(n % 10), {6'h00, grp[n % 10]});
		end
		{stage_start_i, stage_trip_i} = 10'h000;
		wr(por_pkg::SEL_REPLACE_TIMER, 10'h001);
		clear_ind();
		pulse_trip(5'h04);
		check("indication", 10'h00A, {6'h00, indication_o});
		pulse_trip(5'h01);
		check("indication", 10'h00A, {6'h00, indication_o});
		repeat (25) step();
		pulse_trip(5'h02);
		check("indication", 10'h009, {6'h00, indication_o});
		wr(por_pkg::SEL_REPLACE_TIMER, por_pkg::REPLACE_NEVER);
		repeat (25) step();
		pulse_trip(5'h08);
		check("indication", 10'h009, {6'h00, indication_o});
		clear_ind();
		pulse_trip(5'h08);
		check("indication", 10'h00B, {6'h00, indication_o});
		power_restore_i = 1'b1;
		step();
		power_restore_i = 1'b0;
		step();
		check("indication", 10'h00B, {6'h00, indication_o});
		wr(por_pkg::SEL_RETENTION, 10'h01E);
		power_restore_i = 1'b1;
		step();
		power_restore_i = 1'b0;
		step();
		check("valid", 10'h000, {9'h000, indication_o.valid});
		final_report();
	end
endmodule : tb_por_routing
